// ### design/smb_cfg_slave.sv
// What this block does
// - slave only, never starts a transfer
// - takes master writes, returns master reads
// - master reaches every read/write config register
// - autoloadable read-only registers also master-writable
// - address bits 2..0 from three strap pins
// - address bits 6..3 fixed at 1101
// - clock line received, held low while busy
// - both lines open-drain, released when receiving
`timescale 1ns/10ps
module smb_cfg_slave (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic serial_mgmt_data_line_i,
  output logic serial_mgmt_data_line_o,
  output logic serial_mgmt_data_line_oe,
  input wire logic [smb_pkg::STRAP_W-1:0] addr_strap,
  output logic cfg_req,
  output logic cfg_we,
  output logic [smb_pkg::OFF_W-1:0] cfg_off,
  output logic [smb_pkg::BYTE_W-1:0] cfg_wdata,
  input wire logic [smb_pkg::BYTE_W-1:0] cfg_rdata,
  input wire logic cfg_ack
);

  // link domain synchronisers
  logic scl_m, scl_s, scl_p;
  logic sda_m, sda_s, sda_p;
  logic [smb_pkg::STRAP_W-1:0] strap_m, strap_s;
  logic done_m, done_s;
  logic done_tgl_q, done_tgl_d;

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      strap_m <= '0;
      strap_s <= '0;
      done_m <= 1'b0;
      done_s <= 1'b0;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= serial_mgmt_data_line_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
      strap_m <= addr_strap;
      strap_s <= strap_m;
      done_m <= done_tgl_q;
      done_s <= done_m;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [6:0] my_addr;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  assign my_addr = {smb_pkg::ADDR_HI, strap_s};

  // link state machine
  smb_pkg::smb_st_e st_q, st_d;
  smb_pkg::smb_ph_e ph_q, ph_d;
  logic [smb_pkg::BYTE_W-1:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic rw_q, rw_d;
  logic [smb_pkg::OFF_W-1:0] off_q, off_d;
  logic we_q, we_d;
  logic [smb_pkg::BYTE_W-1:0] wd_q, wd_d;
  logic req_tgl_q, req_tgl_d;
  logic done_seen_q, done_seen_d;
  logic sda_oe_q, sda_oe_d;
  logic scl_oe_q, scl_oe_d;
  logic done_ev;
  logic [smb_pkg::BYTE_W-1:0] rdata_q, rdata_d;

  assign done_ev = done_s ^ done_seen_q;

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    off_d = off_q;
    we_d = we_q;
    wd_d = wd_q;
    req_tgl_d = req_tgl_q;
    done_seen_d = done_s;
    unique case (st_q)
      smb_pkg::SMB_IDLE: begin
        cnt_d = smb_pkg::CNT_ZERO;
      end
      smb_pkg::SMB_RX: begin
        if (scl_rise) begin
          sh_d = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + smb_pkg::CNT_ONE;
        end else if (scl_fall && cnt_q == smb_pkg::RX_LAST) begin
          cnt_d = smb_pkg::CNT_ZERO;
          if (ph_q == smb_pkg::SMB_PH_ADDR && sh_q[7:1] != my_addr) begin
            st_d = smb_pkg::SMB_IDLE;
          end else begin
            st_d = smb_pkg::SMB_ACK;
          end
        end
      end
      smb_pkg::SMB_ACK: begin
        if (scl_fall) begin
          st_d = smb_pkg::SMB_RX;
          unique case (ph_q)
            smb_pkg::SMB_PH_ADDR: begin
              rw_d = sh_q[0];
              if (sh_q[0]) begin
                // read: fetch byte at current offset
                ph_d = smb_pkg::SMB_PH_DATA;
                we_d = 1'b0;
                req_tgl_d = ~req_tgl_q;
                st_d = smb_pkg::SMB_WAIT;
              end else begin
                ph_d = smb_pkg::SMB_PH_OFF;
              end
            end
            smb_pkg::SMB_PH_OFF: begin
              off_d = sh_q;
              ph_d = smb_pkg::SMB_PH_DATA;
            end
            default: begin
              // no access-type filter here
              we_d = 1'b1;
              wd_d = sh_q;
              req_tgl_d = ~req_tgl_q;
              st_d = smb_pkg::SMB_WAIT;
            end
          endcase
        end
      end
      smb_pkg::SMB_WAIT: begin
        if (done_ev) begin
          off_d = off_q + smb_pkg::OFF_ONE;
          cnt_d = smb_pkg::CNT_ZERO;
          if (rw_q) begin
            sh_d = rdata_q;
            st_d = smb_pkg::SMB_TX;
          end else begin
            st_d = smb_pkg::SMB_RX;
          end
        end
      end
      smb_pkg::SMB_TX: begin
        if (scl_fall) begin
          sh_d = {sh_q[6:0], 1'b1};
          cnt_d = cnt_q + smb_pkg::CNT_ONE;
          if (cnt_q == smb_pkg::TX_LAST) begin
            st_d = smb_pkg::SMB_MACK;
          end
        end
      end
      smb_pkg::SMB_MACK: begin
        if (scl_rise && sda_s) begin
          st_d = smb_pkg::SMB_IDLE;
        end else if (scl_fall) begin
          we_d = 1'b0;
          req_tgl_d = ~req_tgl_q;
          st_d = smb_pkg::SMB_WAIT;
        end
      end
      default: begin
        st_d = smb_pkg::SMB_IDLE;
      end
    endcase
    if (start_ev) begin
      st_d = smb_pkg::SMB_RX;
      ph_d = smb_pkg::SMB_PH_ADDR;
      cnt_d = smb_pkg::CNT_ZERO;
    end else if (stop_ev) begin
      st_d = smb_pkg::SMB_IDLE;
    end
    // drive low only for ack and zero bits
    sda_oe_d = (st_d == smb_pkg::SMB_ACK) || (st_d == smb_pkg::SMB_TX && !sh_d[7]);
    scl_oe_d = (st_d == smb_pkg::SMB_WAIT);
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= smb_pkg::SMB_IDLE;
      ph_q <= smb_pkg::SMB_PH_ADDR;
      sh_q <= smb_pkg::BYTE_ZERO;
      cnt_q <= smb_pkg::CNT_ZERO;
      rw_q <= 1'b0;
      off_q <= smb_pkg::BYTE_ZERO;
      we_q <= 1'b0;
      wd_q <= smb_pkg::BYTE_ZERO;
      req_tgl_q <= 1'b0;
      done_seen_q <= 1'b0;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      off_q <= off_d;
      we_q <= we_d;
      wd_q <= wd_d;
      req_tgl_q <= req_tgl_d;
      done_seen_q <= done_seen_d;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
    end
  end

  assign scl_o = smb_pkg::OD_LOW;
  assign scl_oe = scl_oe_q;
  assign serial_mgmt_data_line_o = smb_pkg::OD_LOW;
  assign serial_mgmt_data_line_oe = sda_oe_q;

  // core domain: toggle handshake, fields stable while pending
  logic req_m, req_s;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
    end else begin
      req_m <= req_tgl_q;
      req_s <= req_m;
    end
  end

  assign cfg_req = req_s ^ done_tgl_q;
  assign cfg_we = we_q;
  assign cfg_off = off_q;
  assign cfg_wdata = wd_q;

  always_comb begin
    done_tgl_d = done_tgl_q;
    rdata_d = rdata_q;
    if (cfg_req && cfg_ack) begin
      done_tgl_d = ~done_tgl_q;
      if (!cfg_we) begin
        rdata_d = cfg_rdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_tgl_q <= 1'b0;
      rdata_q <= smb_pkg::BYTE_ZERO;
    end else begin
      done_tgl_q <= done_tgl_d;
      rdata_q <= rdata_d;
    end
  end

  a_no_start_gen: assert property (@(posedge link_clk) disable iff (!arst_n)
    $rose(sda_oe_q) |-> !$past(scl_s)) else $error("data line pulled while clock high");
  a_addr_match: assert property (@(posedge link_clk) disable iff (!arst_n)
    (st_q == smb_pkg::SMB_ACK && ph_q == smb_pkg::SMB_PH_ADDR)
    |-> sh_q[7:1] == {4'hd, strap_s}) else $error("acked a foreign address");
  a_addr_high: assert property (@(posedge link_clk) disable iff (!arst_n)
    my_addr[6:3] == 4'hd) else $error("fixed address bits wrong");
  a_ack_drive: assert property (@(posedge link_clk) disable iff (!arst_n)
    st_q == smb_pkg::SMB_ACK |-> sda_oe_q) else $error("ack not driven");
  a_rx_release: assert property (@(posedge link_clk) disable iff (!arst_n)
    st_q == smb_pkg::SMB_RX || st_q == smb_pkg::SMB_MACK |-> !sda_oe_q) else $error("data held while receiving");
  a_tx_bit: assert property (@(posedge link_clk) disable iff (!arst_n)
    st_q == smb_pkg::SMB_TX |-> sda_oe_q == !sh_q[7]) else $error("wrong transmit bit");
  a_stretch_hold: assert property (@(posedge link_clk) disable iff (!arst_n)
    scl_oe_q |-> st_q == smb_pkg::SMB_WAIT && !$past(scl_s)) else $error("clock held outside wait");
  a_req_level: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg_req && !cfg_ack |=> cfg_req) else $error("request dropped before ack");
  a_read_return: assert property (@(posedge core_clk) disable iff (!arst_n)
    cfg_req && cfg_ack && !cfg_we |=> rdata_q == $past(cfg_rdata) && !cfg_req) else $error("read data lost");

endmodule : smb_cfg_slave

// ### common/smb_pkg.sv
package smb_pkg;
  // slave address bits 6..3, fixed
  localparam logic [3:0] ADDR_HI = 4'hd;
  localparam int STRAP_W = 3;
  localparam int BYTE_W = 8;
  localparam int OFF_W = 8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] RX_LAST = 4'h8;
  localparam logic [3:0] TX_LAST = 4'h7;
  localparam logic [7:0] OFF_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic OD_LOW = 1'b0;

  typedef enum logic [2:0] {
    SMB_IDLE = 3'h0,
    SMB_RX = 3'h1,
    SMB_ACK = 3'h2,
    SMB_WAIT = 3'h3,
    SMB_TX = 3'h4,
    SMB_MACK = 3'h5
  } smb_st_e;

  typedef enum logic [1:0] {
    SMB_PH_ADDR = 2'h0,
    SMB_PH_OFF = 2'h1,
    SMB_PH_DATA = 2'h2
  } smb_ph_e;
endpackage : smb_pkg

// ### tb/smb_master.sv
`timescale 1ns/10ps
module smb_master (
  input wire logic scl,
  input wire logic sda,
  output logic scl_m,
  output logic sda_m,
  output logic to
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    to = 1'b0;
  end
  // one bit, waits out clock stretch
  task automatic bit_io(input logic b, output logic r);
    int n;
    #40 sda_m = b;
    #60 scl_m = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #10 n++;
    end
    if (n >= 4000) to = 1'b1;
    #50 r = sda;
    #50 scl_m = 1'b0;
  endtask : bit_io
  task automatic start_c();
    #40 sda_m = 1'b1;
    #60 scl_m = 1'b1;
    #100 sda_m = 1'b0;
    #100 scl_m = 1'b0;
  endtask : start_c
  task automatic stop_c();
    #40 sda_m = 1'b0;
    #60 scl_m = 1'b1;
    #100 sda_m = 1'b1;
    #100;
  endtask : stop_c
  // msb first, then ack bit
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ai, ao);
  endtask : xfer
endmodule : smb_master

// ### tb/smb_cfg_slave_test.sv
`timescale 1ns/10ps
module smb_cfg_slave_test;
  logic core_clk, link_clk, arst_n, scl_oe, sda_oe, scl_m, sda_m, hang, cfg_req, cfg_we, cfg_ack, ak;
  logic [2:0] strap;
  logic [7:0] cfg_off, cfg_wdata, cfg_rdata, q, d0, d1, off, aw;
  logic [7:0] mem [256];
  int num_errors, tests_run, nreq, n0;
  integer seed;
  wire logic scl_drv;
  wire logic sda_drv;
  // open-drain lines with pull-up
  wire logic scl = scl_m & (scl_oe ? scl_drv : 1'b1);
  wire logic sda = sda_m & (sda_oe ? sda_drv : 1'b1);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  smb_cfg_slave DUT (.core_clk(core_clk), .arst_n(arst_n), .link_clk(link_clk), .scl_i(scl), .scl_o(scl_drv),
    .scl_oe(scl_oe), .serial_mgmt_data_line_i(sda), .serial_mgmt_data_line_o(sda_drv),
    .serial_mgmt_data_line_oe(sda_oe), .addr_strap(strap), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_off(cfg_off), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack));
  smb_master M (.scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m), .to(hang));
  assign cfg_rdata = mem[cfg_off];
  // config space stand-in, random stalls
  always @(posedge core_clk) begin
    if (cfg_req === 1'b1 && !cfg_ack && $random(seed) % 2 == 0) begin
      cfg_ack <= #1 1'b1;
      nreq <= nreq + 1;
      if (cfg_we) mem[cfg_off] <= cfg_wdata;
    end else begin
      cfg_ack <= #1 1'b0;
    end
  end
  // write address of the slave for a strap setting
  function automatic logic [7:0] exp_addr(input logic [2:0] a);
    return {4'hd, a, 1'b0};
  endfunction : exp_addr
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #400000;
    chk("watchdog", 8'h01, 8'h00);
    close_out();
  end
  initial begin
    seed = 32'h2d24be58;
    arst_n = 1'b0;
    strap = 3'h0;
    cfg_ack = 1'b0;
    nreq = 0;
    for (int i = 0; i < 256; i++) mem[i] = 8'($random(seed));
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'b1;
    chk("idle", {3'h0, scl_drv, sda_drv, scl_oe, sda_oe, cfg_req}, 8'h00);
    for (int s = 0; s < 8; s++) begin
      @(posedge core_clk) #1 strap = s[2:0];
      off = (s == 7) ? 8'hff : 8'($random(seed));
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      aw = exp_addr(strap);
      #300;
      M.start_c();
      M.xfer(aw, 1'b1, q, ak);
      chk("ack_addr", {7'h00, ak}, 8'h00);
      M.xfer(off, 1'b1, q, ak);
      M.xfer(d0, 1'b1, q, ak);
      M.xfer(d1, 1'b1, q, ak);
      chk("ack_data", {7'h00, ak}, 8'h00);
      M.stop_c();
      chk("wr0", mem[off], d0);
      chk("wr1", mem[off + 8'h01], d1);
      M.start_c();
      M.xfer(aw, 1'b1, q, ak);
      M.xfer(off, 1'b1, q, ak);
      M.start_c();
      M.xfer(aw | 8'h01, 1'b1, q, ak);
      chk("ack_rd", {7'h00, ak}, 8'h00);
      M.xfer(8'hff, 1'b0, q, ak);
      chk("rd0", q, d0);
      M.xfer(8'hff, 1'b1, q, ak);
      chk("rd1", q, d1);
      M.stop_c();
      n0 = nreq;
      M.start_c();
      M.xfer(aw ^ (8'h02 << (s % 7)), 1'b1, q, ak);
      chk("nack", {7'h00, ak}, 8'h01);
      M.xfer(off, 1'b1, q, ak);
      M.stop_c();
      chk("no_access", 8'(nreq - n0), 8'h00);
      chk("hang", {7'h00, hang}, 8'h00);
      if (hang) close_out();
    end
    close_out();
  end
endmodule : smb_cfg_slave_test
